// ---- design/wuc_marker.sv ----
// Write-uncorrectable command interpreter with APB task-file registers
// Overview of operation
// - Command code 45h written by the host starts the sector-marking operation.
// - Option 55h marks every sector of the physical block holding each sector.
// - A read of a pseudo-marked sector waits out full recovery, then sets UNCORRECTABLE_FLAG and ERR.
// - Option AAh marks only the addressed logical sector.
// - A read of a flagged sector sets the uncorrectable flag and error summary.
// - Any other option code aborts the command.
// - Every read-type command, 28-bit or 48-bit, reports a marked sector as bad.
// - A host write to a marked sector stores data, drops the mark and verifies it.
// - A real media defect at a marked place reports the matching error status.
// - Marks are kept in a store that a bus reset does not clear.
// - The command aborts when the mark store is full; an address past the end reports ID not found instead.
// - Sector count is 16 bits, low byte current, high byte previous; zero is 65536.
// - The 48-bit start address spans the current and previous address bytes.
// - On error the first bad address is returned, halves chosen by HIGH_ORDER_BYTE_SELECT select.
// - Option 55h records a log entry; option AAh makes no log entry.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`include "wuc_regs.svh"

module wuc_marker (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        por_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        media_fault,
   output logic             irq
);

   localparam int RECOV_CYC = `WUC_RECOV_CYC;
   localparam int SLOTS     = `WUC_MARK_SLOTS;

   ////////////////////////////////////////////////////////////////////////
   // Command decoding

   function automatic logic is_read_cmd(input logic [7:0] c);
      unique case (c)
         8'h20, 8'h21, 8'h24, 8'h25, 8'h29, 8'h2A, 8'h2B, 8'h40, 8'h41,
         8'h42, 8'hC4, 8'hC8, 8'hC9: is_read_cmd = 1'b1;
         default:                    is_read_cmd = 1'b0;
      endcase
   endfunction

   function automatic logic is_write_cmd(input logic [7:0] c);
      unique case (c)
         8'h30, 8'h31, 8'h34, 8'h35, 8'h39, 8'h3A, 8'h3B, 8'h3D, 8'hC5,
         8'hCA, 8'hCB, 8'hCE: is_write_cmd = 1'b1;
         default:             is_write_cmd = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers and state

   wuc_pkg::wuc_state_e state;
   wuc_pkg::wuc_op_e    op;
   wuc_pkg::wuc_err_s   err;
   wuc_pkg::wuc_mark_s  marks [SLOTS];
   logic [7:0]          feature;
   logic [7:0]          cnt_cur;
   logic [7:0]          cnt_prev;
   logic [7:0]          lo_cur;
   logic [7:0]          lo_prev;
   logic [7:0]          mid_cur;
   logic [7:0]          mid_prev;
   logic [7:0]          hi_cur;
   logic [7:0]          hi_prev;
   logic [7:0]          devsel;
   logic [7:0]          status;
   logic                high_order_byte_select;
   logic                op_pseudo;
   logic [1:0]          int_stat;
   logic [1:0]          int_mask;
   logic [15:0]         log_count;
   logic [47:0]         cur_lba;
   logic [16:0]         remain;
   logic [7:0]          recov_cnt;
   logic                recov_done;

   ////////////////////////////////////////////////////////////////////////
   // APB decode; the slave always answers in the access cycle

   wire       bus_acc  = psel && penable;
   wire       bus_wr   = bus_acc && pwrite;
   wire       bus_rd   = bus_acc && !pwrite;
   wire       busy     = status[`WUC_ST_BSY];
   wire       hit_feat = paddr == `WUC_OFF_FEATURE;
   wire       hit_cnt  = paddr == `WUC_OFF_COUNT;
   wire       hit_lo   = paddr == `WUC_OFF_ADDR_LOW;
   wire       hit_mid  = paddr == `WUC_OFF_ADDR_MID;
   wire       hit_hi   = paddr == `WUC_OFF_ADDR_HIGH;
   wire       hit_dev  = paddr == `WUC_OFF_DEVSEL;
   wire       hit_cmd  = paddr == `WUC_OFF_CMD_STAT;
   wire       hit_err  = paddr == `WUC_OFF_ERROR;
   wire       hit_ist  = paddr == `WUC_OFF_INT_STAT;
   wire       hit_imsk = paddr == `WUC_OFF_INT_MASK;
   wire       hit_ctl  = paddr == `WUC_OFF_CONTROL;
   wire       hit_log  = paddr == `WUC_OFF_LOG_COUNT;
   wire       mapped   = hit_feat | hit_cnt | hit_lo | hit_mid | hit_hi
                         | hit_dev | hit_cmd | hit_err | hit_ist | hit_imsk
                         | hit_ctl | hit_log;
   // Task file is locked while busy, as a real device ignores it then
   wire       tf_wr    = bus_wr && !busy;
   wire [7:0] wbyte    = pwdata[7:0];
   wire       start    = tf_wr && hit_cmd;
   wire       is_mark  = wbyte == `WUC_CMD_MARK;
   wire       opt_ok   = feature == `WUC_OPT_PSEUDO
                         || feature == `WUC_OPT_FLAGGED;
   wire       known    = is_mark || is_read_cmd(wbyte)
                         || is_write_cmd(wbyte);

   assign pready  = 1'b1;
   assign pslverr = bus_acc && !mapped;

   // HIGH_ORDER_BYTE_SELECT select picks the previous or current byte of each pair
   wire [7:0] rd_cnt = high_order_byte_select ? cnt_prev : cnt_cur;
   wire [7:0] rd_lo  = high_order_byte_select ? lo_prev  : lo_cur;
   wire [7:0] rd_mid = high_order_byte_select ? mid_prev : mid_cur;
   wire [7:0] rd_hi  = high_order_byte_select ? hi_prev  : hi_cur;
   wire [7:0] err_byte = {1'b0, err.uncorrectable_flag, 1'b0, err.id_not_found_bit, 1'b0, err.aborted_bit,
                          2'h0};

   wire [31:0] next_prdata =
        hit_cnt  ? {24'h0, rd_cnt}   : hit_lo   ? {24'h0, rd_lo}  :
        hit_mid  ? {24'h0, rd_mid}   : hit_hi   ? {24'h0, rd_hi}  :
        hit_dev  ? {24'h0, devsel}   : hit_cmd  ? {24'h0, status} :
        hit_err  ? {24'h0, err_byte} : hit_ist  ? {30'h0, int_stat} :
        hit_imsk ? {30'h0, int_mask} : hit_ctl  ? {31'h0, high_order_byte_select}    :
        hit_log  ? {16'h0, log_count} : 32'h0;
   assign prdata = bus_rd ? next_prdata : 32'h0;

   ////////////////////////////////////////////////////////////////////////
   // Mark lookup over every slot

   logic [SLOTS-1:0] match;
   logic [SLOTS-1:0] match_pseudo;
   logic [SLOTS-1:0] slot_free;
   genvar g;
   generate
      for (g = 0; g < SLOTS; g++) begin : g_slot
         wire blk_eq = marks[g].lba[47:`WUC_PBLK_SHIFT]
                       == cur_lba[47:`WUC_PBLK_SHIFT];
         assign match[g] = marks[g].valid && (marks[g].pseudo ? blk_eq
                           : marks[g].lba == cur_lba);
         assign match_pseudo[g] = match[g] && marks[g].pseudo;
         assign slot_free[g]    = !marks[g].valid;
      end
   endgenerate

   function automatic logic [3:0] first_free(input logic [SLOTS-1:0] f);
      first_free = 4'h0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (f[i]) begin
            first_free = i[3:0];
         end
      end
   endfunction

   wire        any_hit    = |match;
   wire        any_pseudo = |match_pseudo;
   wire        have_free  = |slot_free;
   wire [3:0]  free_idx   = first_free(slot_free);
   wire        out_range  = cur_lba > `WUC_MAX_LBA;
   wire        last       = remain == 17'h1;
   wire [47:0] blk_base   = {cur_lba[47:`WUC_PBLK_SHIFT],
                             {`WUC_PBLK_SHIFT{1'b0}}};
   // Zero count means 65536 sectors
   wire [16:0] start_cnt  = {cnt_prev, cnt_cur} == 16'h0 ? 17'h10000
                            : {1'b0, cnt_prev, cnt_cur};
   wire [47:0] start_lba  = {hi_prev, mid_prev, lo_prev,
                             hi_cur, mid_cur, lo_cur};

   ////////////////////////////////////////////////////////////////////////
   // Per-sector decisions in the execute and verify states

   wire in_exec   = state == wuc_pkg::WUC_EXEC;
   wire do_alloc  = in_exec && op == wuc_pkg::WUC_OP_MARK && !out_range
                    && !any_hit && have_free;
   // A full mark store makes the operation impossible
   wire no_room   = in_exec && op == wuc_pkg::WUC_OP_MARK && !out_range
                    && !any_hit && !have_free;
   wire do_clear  = in_exec && op == wuc_pkg::WUC_OP_WRITE && !out_range;
   wire rd_fail   = in_exec && op == wuc_pkg::WUC_OP_READ && !out_range
                    && (media_fault || (any_hit
                    && (!any_pseudo || recov_done)));
   wire rd_recov  = in_exec && op == wuc_pkg::WUC_OP_READ && !out_range
                    && !media_fault && any_pseudo && !recov_done;
   wire vf_fail   = state == wuc_pkg::WUC_VERIFY
                    && (any_hit || media_fault);
   wire idn_fail  = in_exec && out_range;
   wire fail      = no_room || rd_fail || vf_fail || idn_fail;
   wire sec_ok    = (in_exec && !fail && !rd_recov && !do_clear)
                    || (state == wuc_pkg::WUC_VERIFY && !vf_fail);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   wuc_pkg::wuc_state_e next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         wuc_pkg::WUC_IDLE: begin
            if (start && known && (!is_mark || opt_ok)) begin
               next_state = wuc_pkg::WUC_EXEC;
            end else if (start) begin
               next_state = wuc_pkg::WUC_DONE;
            end
         end
         wuc_pkg::WUC_EXEC: begin
            if (fail || (sec_ok && last)) begin
               next_state = wuc_pkg::WUC_DONE;
            end else if (rd_recov) begin
               next_state = wuc_pkg::WUC_RECOV;
            end else if (do_clear) begin
               next_state = wuc_pkg::WUC_VERIFY;
            end
         end
         wuc_pkg::WUC_RECOV: begin
            if (recov_cnt == 8'(RECOV_CYC - 1)) begin
               next_state = wuc_pkg::WUC_EXEC;
            end
         end
         wuc_pkg::WUC_VERIFY: begin
            next_state = (fail || last) ? wuc_pkg::WUC_DONE
                         : wuc_pkg::WUC_EXEC;
         end
         wuc_pkg::WUC_DONE: next_state = wuc_pkg::WUC_IDLE;
         default:           next_state = wuc_pkg::WUC_IDLE;
      endcase
   end

   wire abort_now = state == wuc_pkg::WUC_IDLE && start
                    && !(known && (!is_mark || opt_ok));
   wire finish    = state == wuc_pkg::WUC_DONE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= wuc_pkg::WUC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Sector walker and recovery timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op         <= wuc_pkg::WUC_OP_MARK;
         op_pseudo  <= 1'b0;
         cur_lba    <= 48'h0;
         remain     <= 17'h0;
         recov_cnt  <= 8'h0;
         recov_done <= 1'b0;
      end else begin
         if (state == wuc_pkg::WUC_IDLE && start) begin
            op <= is_read_cmd(wbyte)  ? wuc_pkg::WUC_OP_READ  :
                  is_write_cmd(wbyte) ? wuc_pkg::WUC_OP_WRITE :
                  wuc_pkg::WUC_OP_MARK;
            op_pseudo <= feature == `WUC_OPT_PSEUDO;
            cur_lba   <= start_lba;
            remain    <= start_cnt;
         end else if (sec_ok && !last) begin
            cur_lba <= cur_lba + 48'h1;
            remain  <= remain - 17'h1;
         end
         recov_cnt  <= state == wuc_pkg::WUC_RECOV ? recov_cnt + 8'h1
                       : 8'h0;
         recov_done <= state == wuc_pkg::WUC_RECOV;
      end
   end

   // Mark store: cleared only at first power-up, not by bus reset
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         for (int i = 0; i < SLOTS; i++) begin
            marks[i] <= '0;
         end
      end else begin
         for (int i = 0; i < SLOTS; i++) begin
            if (do_clear && match[i]) begin
               marks[i].valid <= 1'b0;
            end else if (do_alloc && free_idx == i[3:0]) begin
               marks[i].valid  <= 1'b1;
               marks[i].pseudo <= op_pseudo;
               marks[i].lba    <= op_pseudo ? blk_base : cur_lba;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Task file, status and error

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         feature  <= 8'h0;
         cnt_cur  <= 8'h0;
         cnt_prev <= 8'h0;
         lo_cur   <= 8'h0;
         lo_prev  <= 8'h0;
         mid_cur  <= 8'h0;
         mid_prev <= 8'h0;
         hi_cur   <= 8'h0;
         hi_prev  <= 8'h0;
         devsel   <= `WUC_DEVSEL_RESET;
         high_order_byte_select      <= 1'b0;
      end else if (fail) begin
         // First failing sector goes back through the address bytes
         {hi_prev, mid_prev, lo_prev, hi_cur, mid_cur, lo_cur}
            <= cur_lba;
      end else if (tf_wr) begin
         // Each count or address write pushes the old current byte into previous
         if (hit_feat) feature <= wbyte;
         if (hit_cnt) {cnt_prev, cnt_cur} <= {cnt_cur, wbyte};
         if (hit_lo)  {lo_prev, lo_cur}   <= {lo_cur, wbyte};
         if (hit_mid) {mid_prev, mid_cur} <= {mid_cur, wbyte};
         if (hit_hi)  {hi_prev, hi_cur}   <= {hi_cur, wbyte};
         if (hit_dev) devsel <= wbyte;
         if (hit_ctl) high_order_byte_select    <= pwdata[`WUC_CTL_HOB];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= `WUC_STATUS_RESET;
         err    <= '0;
      end else if (state == wuc_pkg::WUC_IDLE && start) begin
         status <= 8'h1 << `WUC_ST_BSY;
         err    <= {1'b0, 1'b0, abort_now};
      end else if (fail) begin
         err.uncorrectable_flag <= rd_fail || vf_fail;
         err.id_not_found_bit <= idn_fail;
         err.aborted_bit <= no_room;
      end else if (finish) begin
         // Busy, fault and corrected drop; ERR summarises any error
         status <= (8'h1 << `WUC_ST_RDY) | (8'h1 << `WUC_ST_DSC)
                   | {7'h0, |err};
      end
   end

   // Option 55h leaves a log entry for each block it marks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         log_count <= 16'h0;
      end else if (do_alloc && op_pseudo) begin
         log_count <= log_count + 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts: set wins over the clear-on-read

   wire [1:0] int_set = {finish && |err, finish};
   wire       ist_rd  = bus_rd && hit_ist;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat <= 2'h0;
         int_mask <= `WUC_INT_MASK_RESET;
      end else begin
         int_stat <= (ist_rd ? 2'h0 : int_stat) | int_set;
         if (bus_wr && hit_imsk) int_mask <= pwdata[1:0];
      end
   end
   assign irq = |(int_stat & int_mask);

   ////////////////////////////////////////////////////////////////////////
   // Checks

   property p_bad_opt;
      @(posedge pclk) disable iff (!presetn)
      (state == wuc_pkg::WUC_IDLE && start && is_mark && !opt_ok)
      |=> state == wuc_pkg::WUC_DONE ##1 (err.aborted_bit && status[0]);
   endproperty
   a_bad_opt: assert property (p_bad_opt)
      else $error("bad option not aborted");

   property p_recov;
      @(posedge pclk) disable iff (!presetn)
      $rose(state == wuc_pkg::WUC_RECOV)
      |-> (state == wuc_pkg::WUC_RECOV)[*8];
   endproperty
   a_recov: assert property (p_recov)
      else $error("recovery cut short");

   property p_rd_fail;
      @(posedge pclk) disable iff (!presetn)
      rd_fail |=> ##1 (err.uncorrectable_flag && status[`WUC_ST_ERR]
                       && !status[`WUC_ST_BSY]);
   endproperty
   a_rd_fail: assert property (p_rd_fail)
      else $error("marked read not reported");

   property p_flag_read;
      @(posedge pclk) disable iff (!presetn)
      (in_exec && op == wuc_pkg::WUC_OP_READ && any_hit && !any_pseudo
       && !out_range) |-> rd_fail;
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("flagged read passed");

   property p_alloc;
      @(posedge pclk) disable iff (!presetn || !por_n)
      do_alloc |=> any_hit;
   endproperty
   a_alloc: assert property (p_alloc)
      else $error("mark not stored");

   property p_clear;
      @(posedge pclk) disable iff (!presetn || !por_n)
      do_clear |=> (state == wuc_pkg::WUC_VERIFY && !any_hit);
   endproperty
   a_clear: assert property (p_clear)
      else $error("write left mark");

   property p_log;
      @(posedge pclk) disable iff (!presetn)
      (do_alloc && !op_pseudo) |=> $stable(log_count);
   endproperty
   a_log: assert property (p_log)
      else $error("flagged mark logged");

   property p_addr_back;
      @(posedge pclk) disable iff (!presetn)
      fail |=> {hi_prev, mid_prev, lo_prev, hi_cur, mid_cur, lo_cur}
               == $past(cur_lba);
   endproperty
   a_addr_back: assert property (p_addr_back)
      else $error("failing address not returned");

   property p_done;
      @(posedge pclk) disable iff (!presetn)
      finish |=> !status[`WUC_ST_BSY] && !status[`WUC_ST_DF]
                 && !status[`WUC_ST_COR] && status[0] == |err;
   endproperty
   a_done: assert property (p_done)
      else $error("bad completion status");

   property p_full;
      @(posedge pclk) disable iff (!presetn)
      no_room |=> ##1 (err.aborted_bit && status[`WUC_ST_ERR]);
   endproperty
   a_full: assert property (p_full)
      else $error("full store not aborted");

endmodule

// ---- design/wuc_regs.svh ----
// Register offsets, field positions, codes and timing counts of the marker
`ifndef WUC_REGS_SVH
`define WUC_REGS_SVH

// Byte addresses on the register bus
`define WUC_OFF_FEATURE     8'h00
`define WUC_OFF_COUNT       8'h04
`define WUC_OFF_ADDR_LOW    8'h08
`define WUC_OFF_ADDR_MID    8'h0C
`define WUC_OFF_ADDR_HIGH   8'h10
`define WUC_OFF_DEVSEL      8'h14
`define WUC_OFF_CMD_STAT    8'h18
`define WUC_OFF_ERROR       8'h1C
`define WUC_OFF_INT_STAT    8'h20
`define WUC_OFF_INT_MASK    8'h24
`define WUC_OFF_CONTROL     8'h28
`define WUC_OFF_LOG_COUNT   8'h2C

// Status bits
`define WUC_ST_BSY          7
`define WUC_ST_RDY          6
`define WUC_ST_DF           5
`define WUC_ST_DSC          4
`define WUC_ST_COR          2
`define WUC_ST_ERR          0
// Error bits
`define WUC_ER_UNC          6
`define WUC_ER_IDN          4
`define WUC_ER_ABT          2
// Control bit
`define WUC_CTL_HOB         0
// Interrupt bits
`define WUC_IRQ_DONE        0
`define WUC_IRQ_FAIL        1

`define WUC_STATUS_RESET    8'h50
`define WUC_DEVSEL_RESET    8'hA0
`define WUC_INT_MASK_RESET  2'h0

// Command and option codes
`define WUC_CMD_MARK        8'h45
`define WUC_OPT_PSEUDO      8'h55
`define WUC_OPT_FLAGGED     8'hAA

// Geometry
`define WUC_MARK_SLOTS      16
`define WUC_PBLK_SHIFT      3
`define WUC_MAX_LBA         48'h0001_D1C0_BEAF

// Full error recovery time before a pseudo mark is reported
`define WUC_CLK_NS          5
`define WUC_RECOV_NS        1000
`define WUC_RECOV_CYC       ((`WUC_RECOV_NS + `WUC_CLK_NS - 1) / `WUC_CLK_NS)

`endif

// ---- design/wuc_pkg.sv ----
// Types shared by the write-uncorrectable command block
package wuc_pkg;
   typedef enum logic [2:0] {
      WUC_IDLE   = 3'h0,
      WUC_EXEC   = 3'h1,
      WUC_RECOV  = 3'h3,
      WUC_VERIFY = 3'h2,
      WUC_DONE   = 3'h6
   } wuc_state_e;

   typedef enum logic [1:0] {
      WUC_OP_MARK  = 2'h0,
      WUC_OP_READ  = 2'h1,
      WUC_OP_WRITE = 2'h2
   } wuc_op_e;

   // One non-volatile mark; pseudo marks cover a whole physical block
   typedef struct packed {
      logic        valid;
      logic        pseudo;
      logic [47:0] lba;
   } wuc_mark_s;

   typedef struct packed {
      logic uncorrectable_flag;
      logic id_not_found_bit;
      logic aborted_bit;
   } wuc_err_s;
endpackage

// ---- tb/wuc_host.sv ----
// Host controller model driving the task-file registers over APB
`timescale 1ns/1ps
`include "wuc_regs.svh"
module wuc_host (
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, d,
                       output logic [7:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         tb_top.err_count++;
         tb_top.report_and_stop();
      end
      r = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // High byte first: each write pushes current into previous
   task automatic cmd(input logic [7:0] c, f, input logic [47:0] l);
      logic [7:0] r;
      logic       e;
      xfer(1'b1, `WUC_OFF_FEATURE, f, r, e);
      xfer(1'b1, `WUC_OFF_COUNT, 8'h00, r, e);
      xfer(1'b1, `WUC_OFF_COUNT, 8'h01, r, e);
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, 8'(8 + 4 * i), l[24 + 8 * i +: 8], r, e);
         xfer(1'b1, 8'(8 + 4 * i), l[8 * i +: 8], r, e);
      end
      xfer(1'b1, `WUC_OFF_CMD_STAT, c, r, e);
   endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the write-uncorrectable command block
`timescale 1ns/1ps
`include "wuc_regs.svh"
module tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        por_n = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, irq, e;
   logic        media_fault;
   logic [7:0]  paddr, r, f;
   logic [31:0] pwdata, prdata;
   logic [47:0] l;
   logic [1:0]  msk;
   int          err_count = 0;
   int          samples_checked = 0;
   int          seed = 32'h57e5;
   int          n;
   logic [7:0]  rcode [13] = '{8'h20, 8'h21, 8'h24, 8'h25, 8'h29, 8'h2A,
      8'h2B, 8'h40, 8'h41, 8'h42, 8'hC4, 8'hC8, 8'hC9};
   always #2.5 pclk = ~pclk;
   wuc_host host_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);
   wuc_marker dut_u (.pclk, .presetn, .por_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .media_fault, .irq);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] exp_st(input logic [7:0] er);
      return (er != 8'h00) ? 8'h51 : 8'h50;
   endfunction
   task automatic rd(input logic [7:0] a);
      host_u.xfer(1'b0, a, 8'h00, r, e);
   endtask
   task automatic run(input logic [7:0] c, f, er, input logic [47:0] a);
      host_u.cmd(c, f, a);
      n = 0;
      do begin
         rd(`WUC_OFF_CMD_STAT);
         n++;
      end while (r[7] !== 1'b0 && n < 400);
      if (n >= 400) begin
         err_count++;
         report_and_stop();
      end
      chk(r, exp_st(er));
      rd(`WUC_OFF_ERROR);
      chk(r, er);
      chk(irq, |({er != 8'h00, 1'b1} & msk));
      rd(`WUC_OFF_INT_STAT);
      chk(r, {6'h0, er != 8'h00, 1'b1});
      @(posedge pclk);
      #1 chk(irq, 8'h00);
      $display("test cmd %h opt %h done", c, f);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      media_fault = 1'b0;
      msk = 2'h0;
      l = {28'h0, 20'($random(seed))} & ~48'h7;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
      rd(`WUC_OFF_CMD_STAT);
      chk(r, `WUC_STATUS_RESET);
      rd(`WUC_OFF_DEVSEL);
      chk(r, `WUC_DEVSEL_RESET);
      host_u.xfer(1'b0, 8'h3C, 8'h00, r, e);
      chk(e, 8'h01);
      // Low nibble 8 keeps the random option off both valid codes
      for (int i = 0; i < 4; i++) begin
         // Corners sit one step either side of 55h and one step above AAh
         f = (i == 0) ? 8'h54 : (i == 1) ? 8'h56 : (i == 2) ? 8'hAB
             : 8'($random(seed)) & 8'hF0;
         run(8'h45, f | 8'(i == 3) * 8'h08, 8'h04, l);
      end
      host_u.xfer(1'b1, `WUC_OFF_INT_MASK, 8'h03, r, e);
      msk = 2'h3;
      run(8'h45, `WUC_OPT_FLAGGED, 8'h00, l);
      run(8'h24, 8'h00, 8'h00, l + 1);
      foreach (rcode[i]) run(rcode[i], 8'h00, 8'h40, l);
      chk(8'(n < 10), 8'h01);
      host_u.xfer(1'b1, `WUC_OFF_CONTROL, 8'h00, r, e);
      rd(`WUC_OFF_ADDR_LOW);
      chk(r, l[7:0]);
      host_u.xfer(1'b1, `WUC_OFF_CONTROL, 8'h01, r, e);
      rd(`WUC_OFF_ADDR_LOW);
      chk(r, l[31:24]);
      run(8'h45, `WUC_OPT_PSEUDO, 8'h00, l + 64);
      rd(`WUC_OFF_LOG_COUNT);
      chk(r, 8'h01);
      run(8'h20, 8'h00, 8'h40, l + 69);
      chk(8'(n > `WUC_RECOV_CYC / 4), 8'h01);
      // Bus reset alone must leave the mark store intact
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      msk = 2'h0;
      run(8'h24, 8'h00, 8'h40, l);
      run(8'h34, 8'h00, 8'h00, l);
      run(8'h24, 8'h00, 8'h00, l);
      media_fault <= 1'b1;
      run(8'h34, 8'h00, 8'h40, l + 128);
      media_fault <= 1'b0;
      run(8'h45, `WUC_OPT_FLAGGED, 8'h10, 48'hFFFF_FFFF_FFFF);
      report_and_stop();
   end
endmodule
